// ### tile_security_pkg.sv
// Notes on behaviour
// R1: security bit 0 refuses every debug-port access to processor state or memory; the code gates only jtag_state_grant_o with it, OTP access follows bit 13.
// R2: security bit 1 denies other tiles access to processor state via the switch.
// R3: security bit 5 forces boot from address zero of the OTP, skipping boot ROM.
// R4: security bit 7 enables the redundant rows of the OTP.
// R5: bits 8 to 11 lock programming of OTP sectors 0 to 3 respectively.
// R6: security bit 12 rejects all OTP programming, including the security row.
// R7: security bit 13 blocks debug-port reads and writes of this OTP.
// R8: security bit 14 disables the global debug pin in both directions.
// R9: bits 21 down to 15 are general purpose bits readable by software.
// R10: bits 31 down to 22 hold the user ID extension for the usercode.
// R11: the security word is loaded from OTP at power-up before taking effect.
// R12: OTP is four sectors of 512 rows, each row 32 bits wide.
// R13: usercode user ID field comes from bits 31..22; zero when unprogrammed.
// R14: once loaded, security bits stay fixed until the next power-up load.
// R15: requests before the load completes are held off, never served.
package tile_security_pkg;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned SEC_JTAG_DIS_BIT = 0;
  localparam int unsigned SEC_LINK_DIS_BIT = 1;
  localparam int unsigned SEC_OTP_BOOT_BIT = 5;
  localparam int unsigned SEC_REDUNDANT_BIT = 7;
  localparam int unsigned SEC_SECTOR_LOCK_LSB = 8;
  localparam int unsigned SEC_MASTER_LOCK_BIT = 12;
  localparam int unsigned SEC_JTAG_OTP_DIS_BIT = 13;
  localparam int unsigned SEC_DEBUG_DIS_BIT = 14;
  localparam int unsigned SEC_GP_LSB = 15;
  localparam int unsigned SEC_GP_MSB = 21;
  localparam int unsigned SEC_UID_LSB = 22;
  localparam int unsigned SEC_UID_MSB = 31;

  // ****************************************
  // OTP layout and load
  // ****************************************
  localparam int unsigned OTP_SECTORS = 4;
  localparam int unsigned OTP_ROWS_PER_SECTOR = 512;
  localparam int unsigned OTP_ROW_BITS = 32;
  localparam int unsigned OTP_ADDR_BITS = 11;
  localparam logic [10:0] OTP_SEC_ROW_ADDR = 11'h7ff;
  localparam logic [31:0] SEC_RESET_VAL = 32'h0000_0000;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_SEC_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PROG_ADDR = 8'h08;
  localparam logic [7:0] REG_PROG_DATA = 8'h0c;
  localparam logic [7:0] REG_PROG_CMD = 8'h10;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic valid;
    logic write;
    logic [10:0] addr;
    logic [31:0] data;
  } otp_req_t;

  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
  } otp_rsp_t;

endpackage

// ### otp_guard.sv
`timescale 1ns/10ps
// checks one OTP request against the lock bits
module otp_guard
  import tile_security_pkg::*;
(
  // request
  input wire logic [10:0] addr_i,
  input wire logic is_write_i,
  input wire logic from_jtag_i,
  // settings
  input wire logic [31:0] sec_i,
  // verdict
  output logic allow_o
);
  logic [1:0] sector;
  logic sec_row;
  logic sector_locked;

  always_comb begin
    // R12: four sectors of 512 rows
    sector = addr_i[OTP_ADDR_BITS-1 -: 2];
    sec_row = (addr_i == OTP_SEC_ROW_ADDR);
    // R5: sector locks
    sector_locked = sec_i[SEC_SECTOR_LOCK_LSB + 32'(sector)];
    allow_o = 1'b1;
    if (is_write_i && sector_locked) begin
      allow_o = 1'b0;
    end
    // R6: master lock
    if (is_write_i && sec_i[SEC_MASTER_LOCK_BIT]) begin
      allow_o = 1'b0;
    end
    // R7: debug-port otp block
    if (from_jtag_i && sec_i[SEC_JTAG_OTP_DIS_BIT]) begin
      allow_o = 1'b0;
    end
    // R14: security row not rewritable while the sector 3 lock bit is set
    if (is_write_i && sec_row && sec_i[SEC_SECTOR_LOCK_LSB + 3]) begin
      allow_o = 1'b0;
    end
  end
endmodule

// ### tile_security_config.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module tile_security_config
  import tile_security_pkg::*;
#(
  parameter int unsigned SEC_ROW = 2047
)(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // otp array port
  output otp_req_t otp_req_o,
  input wire otp_rsp_t otp_rsp_i,
  // debug port requests
  input wire logic jtag_state_req_i,
  output logic jtag_state_grant_o,
  input wire logic jtag_otp_req_i,
  input wire logic jtag_otp_write_i,
  input wire logic [10:0] jtag_otp_addr_i,
  input wire logic [31:0] jtag_otp_wdata_i,
  output logic jtag_otp_done_o,
  output logic jtag_otp_ok_o,
  output logic [31:0] jtag_otp_rdata_o,
  // link switch
  input wire logic link_state_req_i,
  output logic link_state_grant_o,
  // boot and otp control
  output logic boot_from_otp_o,
  output logic otp_redundant_en_o,
  output logic [9:0] usercode_uid_o,
  output logic load_done_o,
  // global debug pin
  input wire logic debug_n_i,
  input wire logic debug_break_i,
  output logic debug_n_o,
  output logic debug_n_oe_o,
  output logic debug_req_o
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    ST_LOAD_REQ = 4'b0001,
    ST_LOAD_WAIT = 4'b0010,
    ST_IDLE = 4'b0100,
    ST_OTP_BUSY = 4'b1000
  } state_t;

  state_t state_r;
  logic [31:0] sec_r;
  logic loaded_r;
  logic [10:0] prog_addr_r;
  logic [31:0] prog_data_r;
  logic prog_jtag_r;
  logic prog_write_r;
  logic last_ok_r;
  logic last_reject_r;
  logic [31:0] rd_data_r;
  logic ap_valid_r;
  logic ap_write_r;
  logic [7:0] ap_addr_r;
  logic allow;
  logic bus_go;
  logic cmd_wr;

  wire logic ap_take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
  assign cmd_wr = ap_valid_r && ap_write_r && (ap_addr_r == REG_PROG_CMD);
  assign bus_go = cmd_wr && hwdata_i[0];

  otp_guard u_guard (
    .addr_i(prog_addr_r),
    .is_write_i(prog_write_r),
    .from_jtag_i(prog_jtag_r),
    .sec_i(sec_r),
    .allow_o(allow)
  );

  // ****************************************
  // power-up load and otp sequencer
  // ****************************************
  // R11: load security word at power-up
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= ST_LOAD_REQ;
      loaded_r <= 1'b0;
      sec_r <= SEC_RESET_VAL;
      otp_req_o <= '0;
      prog_addr_r <= '0;
      prog_jtag_r <= 1'b0;
      prog_write_r <= 1'b0;
      last_ok_r <= 1'b0;
      last_reject_r <= 1'b0;
      jtag_otp_done_o <= 1'b0;
      jtag_otp_ok_o <= 1'b0;
      jtag_otp_rdata_o <= '0;
    end else begin
      jtag_otp_done_o <= 1'b0;
      unique case (state_r)
        ST_LOAD_REQ: begin
          otp_req_o <= '{valid: 1'b1, write: 1'b0, addr: 11'(SEC_ROW), data: 32'h0};
          state_r <= ST_LOAD_WAIT;
        end
        ST_LOAD_WAIT: begin
          if (otp_rsp_i.ready) begin
            otp_req_o <= '0;
            // R14: only the power-up load writes the word
            sec_r <= otp_rsp_i.rdata;
            loaded_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // R15: nothing reaches here before the load
          if (jtag_otp_req_i) begin
            prog_addr_r <= jtag_otp_addr_i;
            prog_write_r <= jtag_otp_write_i;
            prog_jtag_r <= 1'b1;
            otp_req_o.data <= jtag_otp_wdata_i;
            state_r <= ST_OTP_BUSY;
          end else if (bus_go) begin
            prog_write_r <= hwdata_i[1];
            prog_jtag_r <= 1'b0;
            prog_addr_r <= prog_addr_r;
            otp_req_o.data <= prog_data_r;
            state_r <= ST_OTP_BUSY;
          end
        end
        ST_OTP_BUSY: begin
          if (!otp_req_o.valid && !allow) begin
            last_ok_r <= 1'b0;
            last_reject_r <= 1'b1;
            jtag_otp_done_o <= prog_jtag_r;
            jtag_otp_ok_o <= 1'b0;
            state_r <= ST_IDLE;
          end else if (!otp_req_o.valid) begin
            otp_req_o.valid <= 1'b1;
            otp_req_o.write <= prog_write_r;
            otp_req_o.addr <= prog_addr_r;
          end else if (otp_rsp_i.ready) begin
            otp_req_o.valid <= 1'b0;
            last_ok_r <= 1'b1;
            last_reject_r <= 1'b0;
            jtag_otp_done_o <= prog_jtag_r;
            jtag_otp_ok_o <= 1'b1;
            jtag_otp_rdata_o <= otp_rsp_i.rdata;
            state_r <= ST_IDLE;
          end
        end
      endcase
      if (state_r == ST_IDLE && !jtag_otp_req_i && cmd_wr && !bus_go) begin
        prog_addr_r <= prog_addr_r;
      end
      if (ap_valid_r && ap_write_r && ap_addr_r == REG_PROG_ADDR) begin
        prog_addr_r <= hwdata_i[10:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prog_data_r <= '0;
    end else if (ap_valid_r && ap_write_r && ap_addr_r == REG_PROG_DATA) begin
      prog_data_r <= hwdata_i;
    end
  end

  // ****************************************
  // access gates
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      jtag_state_grant_o <= 1'b0;
      link_state_grant_o <= 1'b0;
      boot_from_otp_o <= 1'b0;
      otp_redundant_en_o <= 1'b0;
      usercode_uid_o <= '0;
      load_done_o <= 1'b0;
    end else begin
      // R1: debug-port state access
      jtag_state_grant_o <= loaded_r && jtag_state_req_i && !sec_r[SEC_JTAG_DIS_BIT];
      // R2: link switch access
      link_state_grant_o <= loaded_r && link_state_req_i && !sec_r[SEC_LINK_DIS_BIT];
      // R3: secure boot
      boot_from_otp_o <= loaded_r && sec_r[SEC_OTP_BOOT_BIT];
      // R4: redundant rows
      otp_redundant_en_o <= loaded_r && sec_r[SEC_REDUNDANT_BIT];
      // R10: R13: usercode user id
      usercode_uid_o <= loaded_r ? sec_r[SEC_UID_MSB:SEC_UID_LSB] : '0;
      load_done_o <= loaded_r;
    end
  end

  // ****************************************
  // global debug pin
  // ****************************************
  // R8: pin off when disabled
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      debug_n_o <= 1'b0;
      debug_n_oe_o <= 1'b1;
      debug_req_o <= 1'b0;
    end else begin
      debug_n_oe_o <= !(loaded_r && !sec_r[SEC_DEBUG_DIS_BIT] && debug_break_i);
      debug_req_o <= loaded_r && !sec_r[SEC_DEBUG_DIS_BIT] && !debug_n_i;
    end
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= '0;
    end else begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite_i;
      ap_addr_r <= haddr_i;
    end
  end

  // R9: software reads the whole word, general bits included
  always_comb begin
    rd_data_r = 32'h0;
    unique case (haddr_i)
      REG_SEC_CONFIG: rd_data_r = sec_r;
      REG_STATUS: rd_data_r = {28'h0, last_reject_r, last_ok_r, state_r == ST_IDLE, loaded_r};
      REG_PROG_ADDR: rd_data_r = {21'h0, prog_addr_r};
      REG_PROG_DATA: rd_data_r = jtag_otp_rdata_o;
      default: rd_data_r = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hrdata_o <= '0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (ap_take && !hwrite_i) begin
        hrdata_o <= rd_data_r;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_jtag_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
      jtag_state_grant_o |-> !$past(sec_r[SEC_JTAG_DIS_BIT]) && $past(jtag_state_req_i);
  endproperty
  a_jtag_gate: assert property (p_jtag_gate) else $error("debug access granted while disabled"); // R1

  property p_link_gate;
    @(posedge sys_clk_i) disable iff (rst_i) link_state_grant_o |-> !$past(sec_r[SEC_LINK_DIS_BIT]);
  endproperty
  a_link_gate: assert property (p_link_gate) else $error("link access granted while disabled"); // R2

  property p_boot;
    @(posedge sys_clk_i) disable iff (rst_i)
      loaded_r ##1 loaded_r |-> boot_from_otp_o == $past(sec_r[SEC_OTP_BOOT_BIT]);
  endproperty
  a_boot: assert property (p_boot) else $error("boot source mismatch"); // R3

  property p_redund;
    @(posedge sys_clk_i) disable iff (rst_i)
      $past(loaded_r) |-> otp_redundant_en_o == $past(sec_r[SEC_REDUNDANT_BIT]);
  endproperty
  a_redund: assert property (p_redund) else $error("redundant row enable mismatch"); // R4

  property p_lock;
    @(posedge sys_clk_i) disable iff (rst_i)
      otp_req_o.valid && otp_req_o.write |->
        !sec_r[SEC_MASTER_LOCK_BIT] && !sec_r[SEC_SECTOR_LOCK_LSB + 32'(otp_req_o.addr[10:9])];
  endproperty
  a_lock: assert property (p_lock) else $error("write to locked otp"); // R5

  property p_master;
    @(posedge sys_clk_i) disable iff (rst_i)
      sec_r[SEC_MASTER_LOCK_BIT] && loaded_r |-> !(otp_req_o.valid && otp_req_o.write);
  endproperty
  a_master: assert property (p_master) else $error("write under master lock"); // R6

  property p_jtag_otp;
    @(posedge sys_clk_i) disable iff (rst_i) jtag_otp_done_o && sec_r[SEC_JTAG_OTP_DIS_BIT] |-> !jtag_otp_ok_o;
  endproperty
  a_jtag_otp: assert property (p_jtag_otp) else $error("debug otp access served"); // R7

  property p_debug;
    @(posedge sys_clk_i) disable iff (rst_i)
      $past(sec_r[SEC_DEBUG_DIS_BIT]) && $past(loaded_r) |-> debug_n_oe_o && !debug_req_o;
  endproperty
  a_debug: assert property (p_debug) else $error("debug pin active while disabled"); // R8

  property p_fixed;
    @(posedge sys_clk_i) disable iff (rst_i) loaded_r ##1 loaded_r |-> $stable(sec_r);
  endproperty
  a_fixed: assert property (p_fixed) else $error("security word changed after load"); // R14

  property p_hold;
    @(posedge sys_clk_i) disable iff (rst_i) !loaded_r |=> !jtag_state_grant_o && !link_state_grant_o;
  endproperty
  a_hold: assert property (p_hold) else $error("access granted before load"); // R15

  c_load: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(loaded_r));
  c_reject: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(last_reject_r));
  c_grant: cover property (@(posedge sys_clk_i) disable iff (rst_i) jtag_state_grant_o);
endmodule

// ### otp_model.sv
`timescale 1ns/10ps
// ****************************************
// otp array model
// ****************************************
module otp_model
  import tile_security_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // settings
  input wire logic [31:0] sec_word_i,
  input wire logic [1:0] lat_i,
  // array port
  input wire otp_req_t req_i,
  output otp_rsp_t rsp_o,
  output int wr_cnt_o
);
  logic [31:0] mem [int];
  logic [1:0] cnt_r;
  // security word in top row of four 512-row sectors
  always @(posedge clk_i) begin
    rsp_o.ready <= 1'b0;
    // read data is only good with ready, so it churns otherwise
    rsp_o.rdata <= ~rsp_o.rdata;
    if (rst_i) begin
      cnt_r <= 2'h0;
      wr_cnt_o <= 0;
      rsp_o.rdata <= 32'h5a5a_a5a5;
      mem.delete();
      mem[OTP_SEC_ROW_ADDR] = sec_word_i;
    end else if (req_i.valid && !rsp_o.ready) begin
      if (cnt_r != lat_i) begin
        cnt_r <= cnt_r + 2'h1;
      end else begin
        cnt_r <= 2'h0;
        rsp_o.ready <= 1'b1;
        if (req_i.write) begin
          // programming only sets bits
          mem[req_i.addr] = (mem.exists(req_i.addr) ? mem[req_i.addr] : 32'h0) | req_i.data;
          wr_cnt_o <= wr_cnt_o + 1;
        end else begin
          rsp_o.rdata <= mem.exists(req_i.addr) ? mem[req_i.addr] : 32'h0;
        end
      end
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
`define WAITB(c) begin n = 0; while (!(c)) begin @(posedge clk); n++; \
  if (n > 200) begin error_cnt++; conclude(); end end end
module tb_top;
  import tile_security_pkg::*;
  logic clk, hready, hreadyout, hresp, js_gnt, ls_gnt, jo_done, jo_ok, e1;
  logic boot_otp, red_en, load_done, dbg_out, dbg_oe, dbg_req, dbg_pin, okv;
  logic rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, rd_chk = 1'b0;
  logic js_req = 1'b0, ls_req = 1'b0, jo_req = 1'b0, jo_wr = 1'b0;
  logic dbg_brk = 1'b0, ext_low = 1'b0;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0, lat = 2'h0;
  logic [10:0] jo_addr = 11'h0, a;
  logic [31:0] hwdata = 32'h0, jo_wdata = 32'h0, sec = 32'h0, hrdata, jo_rdata, e, r;
  logic [9:0] uid;
  otp_req_t oreq;
  otp_rsp_t orsp;
  int error_cnt = 0, n_tests = 0, seed = 53, wr_cnt, w0, n, k;
  logic [31:0] exp_q[$];
  logic ok_q[$];
  logic [31:0] jrd_q[$];
  assign hready = hreadyout;
  // open-drain debug line with pull-up
  assign dbg_pin = (dbg_oe ? 1'b1 : dbg_out) & !ext_low;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  tile_security_config u_dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .otp_req_o(oreq),
    .otp_rsp_i(orsp), .jtag_state_req_i(js_req), .jtag_state_grant_o(js_gnt),
    .jtag_otp_req_i(jo_req), .jtag_otp_write_i(jo_wr), .jtag_otp_addr_i(jo_addr),
    .jtag_otp_wdata_i(jo_wdata), .jtag_otp_done_o(jo_done), .jtag_otp_ok_o(jo_ok),
    .jtag_otp_rdata_o(jo_rdata), .link_state_req_i(ls_req), .link_state_grant_o(ls_gnt),
    .boot_from_otp_o(boot_otp), .otp_redundant_en_o(red_en), .usercode_uid_o(uid),
    .load_done_o(load_done), .debug_n_i(dbg_pin), .debug_break_i(dbg_brk),
    .debug_n_o(dbg_out), .debug_n_oe_o(dbg_oe), .debug_req_o(dbg_req));
  otp_model u_otp (.clk_i(clk), .rst_i(rst), .sec_word_i(sec), .lat_i(lat), .req_i(oreq),
    .rsp_o(orsp), .wr_cnt_o(wr_cnt));
  // ****************************************
  // bus master and verdict
  // ****************************************
  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic c,
                     output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= ad;
    hwrite <= w;
    @(posedge clk);
    `WAITB(hready)
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    rd_chk <= c;
    if (!w && c) begin
      exp_q.push_back(d);
    end
    @(posedge clk);
    `WAITB(hready)
    rd = hrdata;
    rd_ph <= 1'b0;
  endtask
  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge clk) begin
    if (rd_ph && hready && rd_chk) begin
      e = exp_q.pop_front();
      `CHK({hresp, hrdata}, {1'b0, e})
    end
    if (jo_done) begin
      e1 = ok_q.pop_front();
      e = jrd_q.pop_front();
      `CHK(jo_ok, e1)
      if (e1 && !jo_wr) begin
        `CHK(jo_rdata, e)
      end
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      sec <= (k == 0) ? 32'h0 : (k == 3) ? 32'hffff_ffff : $random(seed);
      lat <= 2'($random(seed));
      rst <= 1'b1;
      js_req <= 1'b1;
      ls_req <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) begin
        @(posedge clk);
        `CHK({js_gnt, ls_gnt}, 2'b00)
      end
      `WAITB(load_done)
      repeat (2) @(posedge clk);
      `CHK({js_gnt, ls_gnt, boot_otp, red_en, uid}, {!sec[0], !sec[1], sec[5], sec[7], sec[31:22]})
      // grants must follow the request down as well
      js_req <= 1'b0;
      ls_req <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK({js_gnt, ls_gnt}, 2'b00)
      bus(1'b0, REG_SEC_CONFIG, sec, 1'b1, r);
      bus(1'b1, REG_SEC_CONFIG, ~sec, 1'b0, r);
      bus(1'b0, REG_SEC_CONFIG, sec, 1'b1, r);
      a = 11'($random(seed));
      jo_wr <= 1'($random(seed));
      @(posedge clk);
      // reads go to the security row, the one row whose content is known
      if (!jo_wr) begin
        a = OTP_SEC_ROW_ADDR;
      end
      okv = !sec[13] && (!jo_wr || !sec[12] && !sec[8 + a[10:9]]);
      ok_q.push_back(okv);
      jrd_q.push_back(sec);
      w0 = wr_cnt;
      jo_req <= 1'b1;
      jo_addr <= a;
      jo_wdata <= $random(seed);
      @(posedge clk);
      jo_req <= 1'b0;
      `WAITB(jo_done)
      @(posedge clk);
      `CHK(wr_cnt - w0, (okv && jo_wr) ? 1 : 0)
      a = 11'($random(seed));
      okv = !sec[12] && !sec[8 + a[10:9]];
      bus(1'b1, REG_PROG_ADDR, {21'h0, a}, 1'b0, r);
      bus(1'b1, REG_PROG_DATA, $random(seed), 1'b0, r);
      w0 = wr_cnt;
      bus(1'b1, REG_PROG_CMD, 32'h3, 1'b0, r);
      r = 32'h0;
      for (n = 0; n < 50 && !r[1]; n++) begin
        bus(1'b0, REG_STATUS, 32'h0, 1'b0, r);
      end
      if (!r[1]) begin
        error_cnt++;
        conclude();
      end
      `CHK(r[3:2], {!okv, okv})
      `CHK(wr_cnt - w0, okv ? 1 : 0)
      dbg_brk <= 1'b1;
      ext_low <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK({dbg_oe, dbg_req, dbg_out}, {sec[14], !sec[14], 1'b0})
      dbg_brk <= 1'b0;
      ext_low <= 1'b0;
    end
    conclude();
  end
  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule
